// file: rtl/fsp_pkg.sv
package fsp_pkg;

  // Instruction codes
  localparam logic [7:0] STATUS_READ_CMD = 8'h05;
  localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
  localparam logic [7:0] ARRAY_READ_CMD = 8'h03;
  localparam logic [7:0] WRITE_ENABLE_CMD = 8'h06;
  localparam logic [7:0] WRITE_DISABLE_CMD = 8'h04;

  // Status byte layout
  localparam int BUSY_FLAG_BIT = 0;
  localparam int WRITE_ENABLE_FLAG_BIT = 1;
  localparam int BLOCK_PROTECT_LO_BIT = 2;
  localparam int BLOCK_PROTECT_HI_BIT = 3;
  localparam int STATUS_LOCK_BIT = 7;
  localparam logic [2:0] ZERO_FIELD = 3'h0;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] UNDERRUN_BYTE = 8'hFF;

  // Framing
  localparam int ADDR_BYTES = 3;
  localparam int ADDR_BITS_DEF = 17;
  localparam int FIFO_DEPTH_DEF = 8;
  // Idle pin levels {protect, data in, clock, select}: high, low, low, high
  localparam logic [3:0] PIN_RESET = 4'h9;

  // Timing: self-timed status write cycle
  localparam int CLK_PERIOD_NS = 50;
  localparam int WS_TIME_NS = 5000000;
  localparam int WS_CYCLES_DEF = (WS_TIME_NS + CLK_PERIOD_NS - 1) /
    CLK_PERIOD_NS;
  localparam int WS_TW = 24;

  typedef enum logic [5:0] {
    ST_CMD = 6'b000001,
    ST_ADDR = 6'b000010,
    ST_RDATA = 6'b000100,
    ST_SRD = 6'b001000,
    ST_WDATA = 6'b010000,
    ST_TAIL = 6'b100000
  } fsp_state_t;

  // ST_TAIL with pend none doubles as the ignore state
  typedef enum logic [1:0] {
    PEND_NONE = 2'h0,
    PEND_WRITE_ENABLE_CMD = 2'h1,
    PEND_WRDI = 2'h2,
    PEND_STATUS = 2'h3
  } fsp_pend_t;

endpackage

// file: rtl/fsp_sync.sv
`timescale 1ns/1ps
module fsp_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
)(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] s1_q, s2_q, s3_q, lvl_q, lvl_d;

  // A level change is accepted once the second and third stages agree
  always_comb
  begin
    lvl_d = (s2_q & ~(s2_q ^ s3_q)) | (lvl_q & (s2_q ^ s3_q));
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      s1_q <= RST_VAL;
      s2_q <= RST_VAL;
      s3_q <= RST_VAL;
      lvl_q <= RST_VAL;
    end
    else
    begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign dout = lvl_q;
endmodule

// file: rtl/fsp_fifo.sv
`timescale 1ns/1ps
module fsp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8,
  parameter int CW = $clog2(DEPTH + 1)
)(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [CW-1:0] count
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0)
  begin : g_chk
    $error("fsp_fifo DEPTH must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [CW-1:0] cnt_q, cnt_d;
  logic push, pop;

  assign in_ready = (cnt_q != CW'(DEPTH));
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign count = cnt_q;
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb
  begin
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (flush)
    begin
      wr_d = '0;
      rd_d = '0;
      cnt_d = '0;
    end
    else
    begin
      if (push)
        wr_d = wr_q + AW'(1);
      if (pop)
        rd_d = rd_q + AW'(1);
      if (push && !pop)
        cnt_d = cnt_q + CW'(1);
      else if (pop && !push)
        cnt_d = cnt_q - CW'(1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end
    else
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (push && !flush)
      mem_q[wr_q] <= in_data;
  end
endmodule

// file: rtl/fsp_top.sv
`timescale 1ns/1ps
// Functional notes
// R1 - Status read is accepted at any time, even during a busy cycle.
// R2 - Status byte repeats on the output while select stays low.
// R3 - Busy flag is 1 during status write, program or erase.
// R4 - With write-enable flag clear, writes, programs and erases are refused.
// R5 - Block-protect bits are non-volatile, changed only by status write.
// R6 - Bulk erase is permitted only when both block-protect bits are 0.
// R7 - Lock bit set and protect pin low make status write refused.
// R8 - Status write is accepted only after write-enable set the flag.
// R9 - Master sends status write code then exactly one data byte.
// R10 - Status write keeps bits 7,3,2; bits 6..4 read zero.
// R11 - Status write executes only if select rises on the byte boundary.
// R12 - Select rise starts timed write; busy held; write-enable flag cleared.
// R13 - Lock bit clear: status write allowed whatever the pin level.
// R14 - Lock bit set, pin high: status write allowed with write-enable.
// R15 - Hardware lock entered by whichever comes last; left on pin high.
// R16 - Protected area refuses program and erase in both lock modes; page_write_permit ignores the protect bits, only full_clear_permit checks them.
// R17 - Address latched on rising clock; data driven on falling clock.
// R18 - Read address increments per byte and wraps to zero.
// R19 - Select high ends the array read at any bit.
// R20 - Array read during a busy cycle is rejected, cycle undisturbed.
// R21 - Upper address bits above the array size are ignored.
// R22 - Master should poll busy before sending new instructions.
// R23 - Write-enable instruction sets the write-enable flag.
// R24 - All codes, addresses and data move most significant bit first.
// R25 - Status: busy bit 0, enable bit 1, protect bits 2-3, lock bit 7.
// R26 - Codes: 05 status read, 01 status write, 03 array read.
module fsp_top
  import fsp_pkg::*;
#(
  parameter int ADDR_BITS = ADDR_BITS_DEF,
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF,
  parameter int WS_CYCLES = WS_CYCLES_DEF
)(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic spi_cs_n,
  input wire logic spi_sck,
  input wire logic spi_mosi,
  input wire logic wp_n,
  output logic spi_miso,
  output logic spi_miso_oe,
  input wire logic ext_busy,
  input wire logic ext_done,
  output logic arr_req_valid,
  input wire logic arr_req_ready,
  output logic [ADDR_BITS-1:0] arr_req_addr,
  input wire logic arr_rd_valid,
  output logic arr_rd_ready,
  input wire logic [7:0] arr_rd_data,
  output logic [7:0] status_byte,
  output logic [1:0] prot_level,
  output logic hardware_lock_mode,
  output logic software_lock_mode,
  output logic page_write_permit,
  output logic full_clear_permit
);
  localparam int CW = $clog2(FIFO_DEPTH + 1);

  if (ADDR_BITS < 1 || ADDR_BITS > 24 || WS_CYCLES < 1 ||
      WS_CYCLES >= 2**WS_TW)
  begin : g_chk
    $error("fsp_top parameter out of range");
  end

  // Pin sampling
  logic [3:0] pin_lvl;
  logic cs_n_lvl, sck_lvl, mosi_lvl, wp_n_lvl;

  fsp_sync #(.WIDTH(4), .RST_VAL(PIN_RESET)) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .din({wp_n, spi_mosi, spi_sck, spi_cs_n}),
    .dout(pin_lvl)
  );
  assign cs_n_lvl = pin_lvl[0];
  assign sck_lvl = pin_lvl[1];
  assign mosi_lvl = pin_lvl[2];
  assign wp_n_lvl = pin_lvl[3];

  logic sck_prev_q, cs_prev_q;
  logic sck_rise, sck_fall, cs_rise;
  assign sck_rise = sck_lvl & ~sck_prev_q & ~cs_n_lvl;
  assign sck_fall = ~sck_lvl & sck_prev_q & ~cs_n_lvl;
  assign cs_rise = cs_n_lvl & ~cs_prev_q;

  // Status and protection state
  logic wel_q, wel_d, lock_q, lock_d, ws_busy_q, ws_busy_d;
  logic [1:0] bp_q, bp_d, nbp_q, nbp_d;
  logic nlock_q, nlock_d;
  logic [WS_TW-1:0] ws_cnt_q, ws_cnt_d;
  logic busy, hw_lock, ws_start;

  // Command engine state
  fsp_state_t st_q, st_d;
  fsp_pend_t pend_q, pend_d;
  logic [2:0] bit_q, bit_d, txc_q, txc_d;
  logic [1:0] abyte_q, abyte_d;
  logic [7:0] sh_q, sh_d, wdat_q, wdat_d, tx_q, tx_d, rx, ld;
  logic [23:0] addr_q, addr_d;
  logic miso_q, miso_d;

  // Prefetch state
  logic [ADDR_BITS-1:0] fetch_q, fetch_d;
  logic [CW-1:0] infl_q, infl_d, fcount;
  logic f_valid, f_pop, reading, req_fire, rsp_fire;
  logic [7:0] f_data;

  assign busy = ws_busy_q | ext_busy; // R3
  assign hw_lock = lock_q & ~wp_n_lvl; // R15

  always_comb
  begin
    status_byte = STATUS_RESET;
    status_byte[BUSY_FLAG_BIT] = busy; // R25
    status_byte[WRITE_ENABLE_FLAG_BIT] = wel_q;
    status_byte[BLOCK_PROTECT_LO_BIT] = bp_q[0];
    status_byte[BLOCK_PROTECT_HI_BIT] = bp_q[1];
    status_byte[6:4] = ZERO_FIELD; // R10
    status_byte[STATUS_LOCK_BIT] = lock_q;
  end

  assign prot_level = bp_q;
  assign hardware_lock_mode = hw_lock;
  assign software_lock_mode = ~hw_lock & (bp_q != 2'h0);
  // Program/erase targets outside the protected area need only the flag and busy clear
  assign page_write_permit = wel_q & ~busy; // R4 R16
  assign full_clear_permit = wel_q & ~busy & (bp_q == 2'h0); // R6 R16

  // Status write is taken only at a byte boundary, gated by lock and flag
  assign ws_start = cs_rise & (pend_q == PEND_STATUS) & wel_q & // R8 R11
    ~hw_lock & ~busy; // R4 R7 R13 R14

  always_comb
  begin
    wel_d = wel_q;
    lock_d = lock_q;
    bp_d = bp_q;
    nlock_d = nlock_q;
    nbp_d = nbp_q;
    ws_busy_d = ws_busy_q;
    ws_cnt_d = ws_cnt_q;
    if (ws_start || ext_done)
      wel_d = 1'b0; // R12
    else if (cs_rise && pend_q == PEND_WRDI)
      wel_d = 1'b0;
    else if (cs_rise && pend_q == PEND_WRITE_ENABLE_CMD && !busy)
      wel_d = 1'b1; // R23
    if (ws_start)
    begin
      ws_busy_d = 1'b1; // R12
      ws_cnt_d = WS_TW'(WS_CYCLES - 1);
      nlock_d = wdat_q[STATUS_LOCK_BIT];
      nbp_d = wdat_q[BLOCK_PROTECT_HI_BIT:BLOCK_PROTECT_LO_BIT];
    end
    else if (ws_busy_q)
    begin
      if (ws_cnt_q == '0)
      begin
        ws_busy_d = 1'b0;
        lock_d = nlock_q; // R5 R10
        bp_d = nbp_q;
      end
      else
        ws_cnt_d = ws_cnt_q - WS_TW'(1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wel_q <= 1'b0;
      lock_q <= STATUS_RESET[STATUS_LOCK_BIT];
      bp_q <= STATUS_RESET[BLOCK_PROTECT_HI_BIT:BLOCK_PROTECT_LO_BIT];
      nlock_q <= 1'b0;
      nbp_q <= 2'h0;
      ws_busy_q <= 1'b0;
      ws_cnt_q <= '0;
    end
    else
    begin
      wel_q <= wel_d;
      lock_q <= lock_d;
      bp_q <= bp_d;
      nlock_q <= nlock_d;
      nbp_q <= nbp_d;
      ws_busy_q <= ws_busy_d;
      ws_cnt_q <= ws_cnt_d;
    end
  end

  // Serial command engine
  assign rx = {sh_q[6:0], mosi_lvl}; // R24
  assign reading = (st_q == ST_RDATA);
  assign ld = (st_q == ST_SRD) ? status_byte :
    (f_valid ? f_data : UNDERRUN_BYTE);
  assign f_pop = sck_fall & reading & (txc_q == 3'h0);

  always_comb
  begin
    st_d = st_q;
    pend_d = pend_q;
    bit_d = bit_q;
    abyte_d = abyte_q;
    sh_d = sh_q;
    wdat_d = wdat_q;
    addr_d = addr_q;
    tx_d = tx_q;
    txc_d = txc_q;
    miso_d = miso_q;
    if (cs_n_lvl)
    begin
      st_d = ST_CMD; // R19
      pend_d = PEND_NONE;
      bit_d = 3'h0;
      abyte_d = 2'h0;
      txc_d = 3'h0;
    end
    else if (sck_rise) // R17
    begin
      sh_d = rx;
      bit_d = bit_q + 3'h1;
      if (st_q == ST_TAIL)
        pend_d = PEND_NONE; // R11
      else if (bit_q == 3'h7)
      begin
        case (st_q)
          ST_CMD:
          begin
            st_d = ST_TAIL;
            case (rx)
              STATUS_READ_CMD: st_d = ST_SRD; // R1 R26
              STATUS_WRITE_CMD: st_d = ST_WDATA; // R9
              ARRAY_READ_CMD: st_d = busy ? ST_TAIL : ST_ADDR; // R20
              WRITE_ENABLE_CMD: pend_d = PEND_WRITE_ENABLE_CMD;
              WRITE_DISABLE_CMD: pend_d = PEND_WRDI;
              default: pend_d = PEND_NONE;
            endcase
          end
          ST_ADDR:
          begin
            addr_d = {addr_q[15:0], rx};
            abyte_d = abyte_q + 2'h1;
            if (abyte_q == 2'(ADDR_BYTES - 1))
              st_d = ST_RDATA;
          end
          ST_WDATA:
          begin
            wdat_d = rx;
            pend_d = PEND_STATUS;
            st_d = ST_TAIL;
          end
          default: st_d = st_q;
        endcase
      end
    end
    else if (sck_fall && (st_q == ST_SRD || reading)) // R17
    begin
      if (txc_q == 3'h0)
      begin
        miso_d = ld[7]; // R2 R24
        tx_d = {ld[6:0], 1'b0};
        txc_d = 3'h7;
      end
      else
      begin
        miso_d = tx_q[7];
        tx_d = {tx_q[6:0], 1'b0};
        txc_d = txc_q - 3'h1;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      st_q <= ST_CMD;
      pend_q <= PEND_NONE;
      bit_q <= 3'h0;
      abyte_q <= 2'h0;
      sh_q <= 8'h00;
      wdat_q <= 8'h00;
      addr_q <= 24'h000000;
      tx_q <= 8'h00;
      txc_q <= 3'h0;
      miso_q <= 1'b0;
      sck_prev_q <= 1'b0;
      cs_prev_q <= 1'b1;
    end
    else
    begin
      st_q <= st_d;
      pend_q <= pend_d;
      bit_q <= bit_d;
      abyte_q <= abyte_d;
      sh_q <= sh_d;
      wdat_q <= wdat_d;
      addr_q <= addr_d;
      tx_q <= tx_d;
      txc_q <= txc_d;
      miso_q <= miso_d;
      sck_prev_q <= sck_lvl;
      cs_prev_q <= cs_n_lvl;
    end
  end

  assign spi_miso = miso_q;
  assign spi_miso_oe = ~cs_n_lvl;

  // Array prefetch: requests bounded by free FIFO room
  assign arr_req_valid = reading &
    ((CW + 1)'(infl_q) + (CW + 1)'(fcount) < (CW + 1)'(FIFO_DEPTH));
  assign arr_req_addr = fetch_q;
  assign req_fire = arr_req_valid & arr_req_ready;
  assign rsp_fire = arr_rd_valid & arr_rd_ready;

  always_comb
  begin
    fetch_d = fetch_q;
    infl_d = infl_q;
    if (st_q == ST_ADDR && st_d == ST_RDATA)
      fetch_d = addr_d[ADDR_BITS-1:0]; // R21
    else if (req_fire)
      fetch_d = fetch_q + ADDR_BITS'(1); // R18
    if (req_fire && !rsp_fire)
      infl_d = infl_q + CW'(1);
    else if (rsp_fire && !req_fire && infl_q != '0)
      infl_d = infl_q - CW'(1);
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      fetch_q <= '0;
      infl_q <= '0;
    end
    else
    begin
      fetch_q <= fetch_d;
      infl_q <= infl_d;
    end
  end

  fsp_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .flush(~reading),
    .in_valid(arr_rd_valid),
    .in_ready(arr_rd_ready),
    .in_data(arr_rd_data),
    .out_valid(f_valid),
    .out_ready(f_pop),
    .out_data(f_data),
    .count(fcount)
  );

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  sequence s_status_code;
    sck_rise && st_q == ST_CMD && bit_q == 3'h7 && rx == STATUS_READ_CMD;
  endsequence

  sequence s_read_code_busy;
    sck_rise && st_q == ST_CMD && bit_q == 3'h7 &&
      rx == ARRAY_READ_CMD && busy;
  endsequence

  a_status_anytime: assert property ( // R1
    s_status_code |=> st_q == ST_SRD)
    else $error("status read not accepted");

  a_busy_bit: assert property ( // R3
    ws_busy_q && ws_cnt_q == '0 |=> status_byte[BUSY_FLAG_BIT] == ext_busy)
    else $error("busy flag not cleared at write cycle end");

  a_start_needs_wel: assert property ( // R8
    ws_start |-> wel_q && pend_q == PEND_STATUS && !hw_lock)
    else $error("status write without enable or under lock");

  a_zero_field: assert property ( // R10
    status_byte[6:4] == 3'h0)
    else $error("reserved status bits not zero");

  a_cycle_start: assert property ( // R12
    ws_start |=> ws_busy_q && !wel_q && busy)
    else $error("write cycle start wrong");

  a_nv_hold: assert property ( // R5
    !(ws_busy_q && ws_cnt_q == '0) |=> $stable(bp_q) && $stable(lock_q))
    else $error("protect bits changed outside a status write");

  a_read_reject: assert property ( // R20
    s_read_code_busy |=> st_q == ST_TAIL && !arr_req_valid)
    else $error("array read accepted while busy");

  a_addr_wrap: assert property ( // R18
    req_fire && fetch_q == '1 && st_q == ST_RDATA |=> fetch_q == '0)
    else $error("read address did not wrap");

  a_cs_ends: assert property ( // R19
    cs_rise |=> st_q == ST_CMD && txc_q == 3'h0 && !arr_req_valid)
    else $error("select rise did not end the transfer");

  a_write_enable_cmd_sets: assert property ( // R23
    cs_rise && pend_q == PEND_WRITE_ENABLE_CMD && !busy && !ext_done |=> wel_q)
    else $error("write enable not set");

  a_bulk_gate: assert property ( // R6
    full_clear_permit |-> bp_q == 2'h0 && wel_q)
    else $error("bulk erase permitted under protection");
endmodule

// file: sim/fsp_spi_master.sv
`timescale 1ns/1ps
module fsp_spi_master (
  input wire logic clk,
  output logic cs_n,
  output logic sck,
  output logic mosi,
  input wire logic miso,
  output logic rx_stb,
  output logic [7:0] rx_byte
);
  initial
  begin
    cs_n = 1'b1;
    sck = 1'b0;
    mosi = 1'b0;
    rx_stb = 1'b0;
    rx_byte = 8'h00;
  end

  // Clock low 5 cycles, high 3; it stands still between frames
  task automatic bits(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++)
    begin
      repeat (2) @(negedge clk);
      mosi = b[7-i];
      repeat (3) @(negedge clk);
      rx_byte = {rx_byte[6:0], miso};
      sck = 1'b1;
      repeat (3) @(negedge clk);
      sck = 1'b0;
    end
  endtask

  task automatic sel();
    @(negedge clk);
    cs_n = 1'b0;
    repeat (4) @(negedge clk);
  endtask

  // Deselects wherever the last clock left off; the released data line flips
  task automatic desel();
    @(negedge clk);
    cs_n = 1'b1;
    mosi = ~mosi;
    repeat (8) @(negedge clk);
  endtask

  task automatic put(input logic [7:0] b);
    bits(b, 8);
  endtask

  task automatic get();
    bits(8'($urandom), 8);
    rx_stb = 1'b1;
    @(negedge clk);
    rx_stb = 1'b0;
  endtask
endmodule

// file: sim/tb_fsp_top.sv
`timescale 1ns/1ps
module tb_fsp_top;
  import fsp_pkg::*;
  localparam int WS = 400;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic wp_n = 1'b1;
  logic ext_busy = 1'b0;
  logic ext_done = 1'b0;
  logic arr_rd_valid = 1'b0;
  logic [7:0] arr_rd_data = 8'h00;
  logic req_seen = 1'b0;
  logic cs_n, sck, mosi, miso, oe, req_v, rd_rdy, hlm, slm, pwp, fcp;
  logic rx_stb;
  logic [7:0] rx_byte, st;
  logic [16:0] req_a;
  logic [1:0] pl;
  int n_errors = 0;
  int n_checks = 0;
  logic [7:0] exp_q[$];

  always #25 clk = ~clk;

  fsp_spi_master m_u (.clk(clk), .cs_n(cs_n), .sck(sck), .mosi(mosi),
    .miso(miso), .rx_stb(rx_stb), .rx_byte(rx_byte));

  fsp_top #(.WS_CYCLES(WS)) dut_u (.clk(clk), .sys_rst(sys_rst),
    .spi_cs_n(cs_n), .spi_sck(sck), .spi_mosi(mosi), .wp_n(wp_n),
    .spi_miso(miso), .spi_miso_oe(oe), .ext_busy(ext_busy),
    .ext_done(ext_done), .arr_req_valid(req_v), .arr_req_ready(1'b1),
    .arr_req_addr(req_a), .arr_rd_valid(arr_rd_valid),
    .arr_rd_ready(rd_rdy), .arr_rd_data(arr_rd_data), .status_byte(st),
    .prot_level(pl), .hardware_lock_mode(hlm),
    .software_lock_mode(slm), .page_write_permit(pwp),
    .full_clear_permit(fcp));

  // Array answers at the falling edge in the same cycle as each request
  always @(negedge clk)
  begin
    arr_rd_valid <= 1'b0;
    if (req_v)
    begin
      req_seen <= 1'b1;
      arr_rd_valid <= 1'b1;
      arr_rd_data <= req_a[7:0] ^ {req_a[16], 7'h00};
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  always @(posedge rx_stb)
  begin
    if (exp_q.size() == 0)
      chk(rx_byte, 8'hXX);
    else
      chk(rx_byte, exp_q.pop_front());
  end

  task automatic wrap_up();
    if (exp_q.size() != 0)
    begin
      n_errors++;
      $display("Error at %0t: expected bytes never arrived", $time);
    end
    $display("Checks %0d, errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic status_read_cmd(input logic [7:0] e, input int n);
    m_u.sel();
    m_u.put(STATUS_READ_CMD);
    repeat (n)
    begin
      exp_q.push_back(e);
      m_u.get();
    end
    m_u.desel();
  endtask

  task automatic cmd(input logic [7:0] c);
    m_u.sel();
    m_u.put(c);
    m_u.desel();
  endtask

  task automatic status_write_cmd(input logic [7:0] d, input int extra);
    m_u.sel();
    m_u.put(STATUS_WRITE_CMD);
    m_u.put(d);
    if (extra > 0)
      m_u.bits(8'hFF, extra);
    m_u.desel();
  endtask

  task automatic pause(input int n);
    repeat (n) @(negedge clk);
  endtask

  initial
  begin
    repeat (50000) @(posedge clk);
    n_errors++;
    $display("Error at %0t: run did not finish", $time);
    wrap_up();
  end

  initial
  begin
    void'($urandom(32'hcaeb9c54));
    pause(3);
    sys_rst = 1'b0;
    pause(4);
    chk({7'h0, oe}, 8'h00);
    chk({6'h0, fcp, pwp}, 8'h00);
    status_read_cmd(8'h00, 2);
    cmd(WRITE_ENABLE_CMD);
    status_read_cmd(8'h02, 1);
    chk({6'h0, fcp, pwp}, 8'h03);
    status_write_cmd(8'hFF, 0);
    status_read_cmd(8'h01, 2);
    pause(WS + 20);
    status_read_cmd(8'h8C, 1);
    chk(st, 8'h8C);
    chk({6'h0, pl}, 8'h03);
    cmd(WRITE_ENABLE_CMD);
    chk({7'h0, fcp}, 8'h00);
    wp_n = 1'b0;
    pause(4);
    chk({6'h0, hlm, slm}, 8'h02);
    status_write_cmd(8'h00, 0);
    pause(WS + 20);
    status_read_cmd(8'h8E, 1);
    wp_n = 1'b1;
    pause(4);
    chk({6'h0, hlm, slm}, 8'h01);
    status_write_cmd(8'h00, 0);
    pause(WS + 20);
    status_read_cmd(8'h00, 1);
    status_write_cmd(8'h8C, 0);
    pause(WS + 20);
    status_read_cmd(8'h00, 1);
    cmd(WRITE_ENABLE_CMD);
    status_write_cmd(8'h0C, 1);
    pause(WS + 20);
    status_read_cmd(8'h02, 1);
    wp_n = 1'b0;
    status_write_cmd(8'h84, 0);
    pause(WS + 20);
    status_read_cmd(8'h84, 1);
    chk({7'h0, hlm}, 8'h01);
    wp_n = 1'b1;
    cmd(WRITE_ENABLE_CMD);
    status_write_cmd(8'h00, 0);
    pause(WS + 20);
    m_u.sel();
    m_u.put(ARRAY_READ_CMD);
    m_u.put(8'hFF);
    m_u.put(8'hFF);
    m_u.put(8'hFE);
    foreach (exp_q[i]) chk(8'h00, 8'h01);
    exp_q = '{8'h7E, 8'h7F, 8'h00, 8'h01};
    repeat (4) m_u.get();
    m_u.bits(8'h00, 3);
    m_u.desel();
    chk({7'h0, oe}, 8'h00);
    req_seen = 1'b0;
    ext_busy = 1'b1;
    pause(2);
    m_u.sel();
    m_u.put(ARRAY_READ_CMD);
    repeat (4) m_u.put(8'h00);
    m_u.desel();
    chk({7'h0, req_seen}, 8'h00);
    status_read_cmd(8'h01, 1);
    ext_busy = 1'b0;
    ext_done = 1'b1;
    pause(1);
    ext_done = 1'b0;
    pause(2);
    status_read_cmd(8'h00, 1);
    wrap_up();
  end
endmodule
